// ===== design/ecia_defines.svh
`ifndef ECIA_DEFINES_SVH
`define ECIA_DEFINES_SVH

// ************************************************
// register byte addresses
// ************************************************
`define ECIA_ADDR_INDIRECT 12'h0f8
`define ECIA_ADDR_DATA 12'h0fc
`define ECIA_ADDR_ECAP 12'h100
`define ECIA_ADDR_BRIDGE 12'h200
`define ECIA_ADDR_INTCTL 12'h210

// ************************************************
// field positions
// ************************************************
`define ECIA_REGNUM_MSB 7
`define ECIA_REGNUM_LSB 2
`define ECIA_EXTNUM_MSB 11
`define ECIA_EXTNUM_LSB 8
`define ECIA_ACTION_MSB 2
`define ECIA_ACTION_LSB 0

// ************************************************
// reset and constant values
// ************************************************
`define ECIA_RST_WORD 32'h0000_0000
`define ECIA_ECAP_VALUE 32'h0000_0000
`define ECIA_RST_ACTION 3'h0

// ************************************************
// link-up action codes
// ************************************************
`define ECIA_ACT_MASKED 3'h0
`define ECIA_ACT_MSI 3'h1
`define ECIA_ACT_INTA 3'h2
`define ECIA_ACT_INTB 3'h3
`define ECIA_ACT_INTC 3'h4
`define ECIA_ACT_INTD 3'h5

`endif

// ===== design/ecia_pkg.sv
`default_nettype none
package ecia_pkg;
  typedef logic [31:0] ecia_word_t;
  typedef logic [11:0] ecia_addr_t;
  typedef logic [3:0] ecia_be_t;
  typedef logic [2:0] ecia_action_t;
  typedef logic [1:0] ecia_pin_t;
  typedef enum logic {ECIA_N_IDLE, ECIA_N_ASSERTED} ecia_ntf_state_t;

  typedef struct packed {
    logic [5:0] reg_num;
    logic [3:0] ext_reg_num;
    ecia_word_t bridge_cfg;
    ecia_action_t action;
    ecia_word_t rdata;
    logic ack;
  } ecia_top_state_t;

  typedef struct packed {
    ecia_ntf_state_t state;
    logic link_q;
    ecia_pin_t pin;
    logic msi;
    logic asrt;
    logic neg;
  } ecia_ntf_reg_t;
endpackage
`default_nettype wire

// ===== design/ecia_ntf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ecia_ntf_if;
  import ecia_pkg::*;
  ecia_action_t action;
  logic link_up;
  logic msi_en;
  logic intx_dis;
  logic msi_send;
  logic intx_assert;
  logic intx_negate;
  ecia_pin_t intx_pin;
  modport ctl (output action, output link_up, output msi_en, output intx_dis,
               input msi_send, input intx_assert, input intx_negate, input intx_pin);
  modport ntf (input action, input link_up, input msi_en, input intx_dis,
               output msi_send, output intx_assert, output intx_negate, output intx_pin);
endinterface
`default_nettype wire

// ===== design/ecia_link_notify.sv
`timescale 1ns/1ps
`default_nettype none
`include "ecia_defines.svh"
module ecia_link_notify (
  input wire logic sys_clk,
  input wire logic rst_n,
  ecia_ntf_if.ntf nif
);
  import ecia_pkg::*;

  // ************************************************
  // state
  // ************************************************
  ecia_ntf_reg_t st_r;
  ecia_ntf_reg_t st_nxt;
  logic rise;
  logic fall;

  assign rise = nif.link_up & ~st_r.link_q;
  assign fall = ~nif.link_up & st_r.link_q;

  always_comb begin
    st_nxt = st_r;
    st_nxt.msi = 1'b0;
    st_nxt.asrt = 1'b0;
    st_nxt.neg = 1'b0;
    st_nxt.link_q = nif.link_up;
    case (st_r.state)
      ECIA_N_IDLE: begin
        if (rise) begin
          if (nif.action == `ECIA_ACT_MSI) begin
            st_nxt.msi = nif.msi_en; // [RULE9] [RULE10] [RULE11]
          end else if (nif.action >= `ECIA_ACT_INTA && nif.action <= `ECIA_ACT_INTD && !nif.intx_dis) begin
            // code three maps to the second pin [RULE14]
            st_nxt.asrt = 1'b1; // [RULE10] [RULE12]
            st_nxt.pin = 2'(nif.action - `ECIA_ACT_INTA); // [RULE9]
            st_nxt.state = ECIA_N_ASSERTED;
          end
        end
      end
      ECIA_N_ASSERTED: begin
        // negation always follows an assertion so no pin is left stuck
        if (fall) begin
          st_nxt.neg = 1'b1; // [RULE10]
          st_nxt.state = ECIA_N_IDLE;
        end
      end
      default: st_nxt.state = ECIA_N_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign nif.msi_send = st_r.msi;
  assign nif.intx_assert = st_r.asrt;
  assign nif.intx_negate = st_r.neg;
  assign nif.intx_pin = st_r.pin;

  // ************************************************
  // checks
  // ************************************************
  a_msi_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE11]
    nif.msi_send |-> $past(nif.msi_en) && $past(nif.action) == `ECIA_ACT_MSI
      && $past(nif.link_up) && !$past(nif.link_up, 2))
    else $error("msi sent without enable or msi code");
  a_intx_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE12]
    nif.intx_assert |-> !$past(nif.intx_dis))
    else $error("intx asserted while disabled");
  a_intx_pin_map: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE14]
    nif.intx_assert |-> nif.intx_pin == 2'($past(nif.action) - `ECIA_ACT_INTA))
    else $error("intx pin does not match action code");
  a_negate_on_fall: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE10]
    (st_r.state == ECIA_N_ASSERTED && $fell(nif.link_up)) |=> nif.intx_negate)
    else $error("no negation after link-up status cleared");
  a_masked_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE9]
    (rise && nif.action == `ECIA_ACT_MASKED) |=> !nif.msi_send && !nif.intx_assert)
    else $error("masked action produced a message");
  c_msi_sent: cover property (@(posedge sys_clk) disable iff (!rst_n) nif.msi_send);
  c_intx_cycle: cover property (@(posedge sys_clk) disable iff (!rst_n)
    nif.intx_assert ##[1:50] nif.intx_negate);
endmodule
`default_nettype wire

// ===== design/ecia_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ecia_defines.svh"
// Function
// [RULE1] indirect index from register and extended numbers
// [RULE2] data reads return the selected register
// [RULE3] data writes update the selected register
// [RULE4] data access byte enables reach target
// [RULE5] self-selection reads zero, writes dropped
// [RULE6] host avoids far-side indirect registers
// [RULE7] extended capability header reads all zero
// [RULE8] reserved bridge register writable, resets zero
// [RULE9] link-up action code selects notification kind
// [RULE10] act on set; intx negate on clear
// [RULE11] msi only when msi enable set
// [RULE12] intx only when not interrupt-disabled
// [RULE13] software keeps action stable while status set
// [RULE14] action code three means second intx pin
module ecia_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire ecia_pkg::ecia_addr_t cfg_addr,
  input wire ecia_pkg::ecia_be_t cfg_be,
  input wire ecia_pkg::ecia_word_t cfg_wdata,
  output logic cfg_ack,
  output ecia_pkg::ecia_word_t cfg_rdata,
  input wire logic link_up_status,
  input wire logic msi_enable,
  input wire logic legacy_interrupt_disable,
  output logic msi_send,
  output logic intx_assert,
  output logic intx_negate,
  output ecia_pkg::ecia_pin_t intx_pin
);
  import ecia_pkg::*;

  // ************************************************
  // helpers
  // ************************************************
  function automatic ecia_word_t be_mask(input ecia_be_t be);
    ecia_word_t m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  function automatic ecia_word_t merge_be(input ecia_word_t old_v, input ecia_word_t new_v, input ecia_be_t be);
    ecia_word_t m;
    m = be_mask(be);
    return (old_v & ~m) | (new_v & m); // [RULE4]
  endfunction

  // one decoder for direct and indirect reads
  function automatic ecia_word_t read_word(input ecia_addr_t a, input ecia_top_state_t s);
    ecia_word_t v;
    v = '0;
    case ({a[11:2], 2'b00})
      `ECIA_ADDR_INDIRECT: begin
        v[`ECIA_REGNUM_MSB:`ECIA_REGNUM_LSB] = s.reg_num;
        v[`ECIA_EXTNUM_MSB:`ECIA_EXTNUM_LSB] = s.ext_reg_num;
      end
      `ECIA_ADDR_ECAP: v = `ECIA_ECAP_VALUE; // [RULE7]
      `ECIA_ADDR_BRIDGE: v = s.bridge_cfg;
      `ECIA_ADDR_INTCTL: v[`ECIA_ACTION_MSB:`ECIA_ACTION_LSB] = s.action;
      default: v = '0;
    endcase
    return v;
  endfunction

  // ************************************************
  // register file
  // ************************************************
  ecia_top_state_t st_r;
  ecia_top_state_t st_nxt;
  ecia_addr_t sel_addr;
  ecia_addr_t tgt;
  logic is_ind;
  logic blocked;
  ecia_word_t w;

  assign sel_addr = {st_r.ext_reg_num, st_r.reg_num, 2'b00}; // [RULE1]
  assign is_ind = cfg_addr[11:2] == 10'(`ECIA_ADDR_DATA >> 2);
  assign tgt = is_ind ? sel_addr : {cfg_addr[11:2], 2'b00}; // [RULE2] [RULE3]
  assign blocked = is_ind && sel_addr == `ECIA_ADDR_DATA; // [RULE5]

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    w = '0;
    if (cfg_req) begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = '0;
      if (cfg_we) begin
        if (!blocked) begin // [RULE5]
          case (tgt)
            `ECIA_ADDR_INDIRECT: begin
              w = merge_be(read_word(tgt, st_r), cfg_wdata, cfg_be);
              st_nxt.reg_num = w[`ECIA_REGNUM_MSB:`ECIA_REGNUM_LSB]; // [RULE1]
              st_nxt.ext_reg_num = w[`ECIA_EXTNUM_MSB:`ECIA_EXTNUM_LSB]; // [RULE1]
            end
            `ECIA_ADDR_BRIDGE: st_nxt.bridge_cfg = merge_be(st_r.bridge_cfg, cfg_wdata, cfg_be); // [RULE8] [RULE3]
            `ECIA_ADDR_INTCTL: begin
              // changing it while status is set is the host's hazard
              w = merge_be(read_word(tgt, st_r), cfg_wdata, cfg_be);
              st_nxt.action = w[`ECIA_ACTION_MSB:`ECIA_ACTION_LSB]; // [RULE9]
            end
            default: st_nxt.action = st_r.action;
          endcase
        end
      end else if (!blocked) begin
        st_nxt.rdata = read_word(tgt, st_r) & be_mask(cfg_be); // [RULE2] [RULE4]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_ack = st_r.ack;
  assign cfg_rdata = st_r.rdata;

  // ************************************************
  // link-up notification
  // ************************************************
  ecia_ntf_if nif ();

  assign nif.action = st_r.action;
  assign nif.link_up = link_up_status;
  assign nif.msi_en = msi_enable;
  assign nif.intx_dis = legacy_interrupt_disable;
  assign msi_send = nif.msi_send;
  assign intx_assert = nif.intx_assert;
  assign intx_negate = nif.intx_negate;
  assign intx_pin = nif.intx_pin;

  ecia_link_notify u_notify (
    .sys_clk (sys_clk),
    .rst_n (rst_n),
    .nif (nif)
  );

  // ************************************************
  // checks
  // ************************************************
  a_addr_fields: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE1]
    (cfg_req && cfg_we && cfg_addr == `ECIA_ADDR_INDIRECT && cfg_be == 4'hf)
    |=> sel_addr == {$past(cfg_wdata[11:2]), 2'b00})
    else $error("indirect address fields not loaded");
  a_addr_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE1]
    (cfg_req && !cfg_we && cfg_addr == `ECIA_ADDR_INDIRECT)
    |=> cfg_rdata[31:12] == 20'h0 && cfg_rdata[1:0] == 2'h0)
    else $error("reserved address register bits not zero");
  a_ack_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE2]
    cfg_req
    |=> cfg_ack)
    else $error("access not answered in one cycle");
  a_ack_source: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE2]
    cfg_ack
    |-> $past(cfg_req))
    else $error("answer without a request");
  a_ind_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE2]
    (cfg_req && !cfg_we && is_ind && sel_addr == `ECIA_ADDR_BRIDGE && cfg_be == 4'hf)
    |=> cfg_ack && cfg_rdata == $past(st_r.bridge_cfg))
    else $error("indirect read returned wrong value");
  a_ind_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE3]
    (cfg_req && cfg_we && is_ind && sel_addr == `ECIA_ADDR_BRIDGE && cfg_be == 4'hf)
    |=> st_r.bridge_cfg == $past(cfg_wdata))
    else $error("indirect write did not update target");
  a_ind_addr_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE3]
    (cfg_req && cfg_we && is_ind && sel_addr == `ECIA_ADDR_INDIRECT && cfg_be == 4'hf)
    |=> sel_addr == {$past(cfg_wdata[11:2]), 2'b00})
    else $error("indirect write to address register lost");
  a_write_rdata: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE3]
    (cfg_req && cfg_we)
    |=> cfg_rdata == 32'h0)
    else $error("read data not zero after a write");
  a_byte_lane: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE4]
    (cfg_req && cfg_we && is_ind && sel_addr == `ECIA_ADDR_BRIDGE && !cfg_be[0])
    |=> $stable(st_r.bridge_cfg[7:0]))
    else $error("disabled byte lane was written");
  a_ind_lane_high: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE4]
    (cfg_req && cfg_we && is_ind && sel_addr == `ECIA_ADDR_BRIDGE && !cfg_be[3])
    |=> $stable(st_r.bridge_cfg[31:24]))
    else $error("disabled top byte lane was written");
  a_read_lane_mask: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE4]
    (cfg_req && !cfg_we && !cfg_be[3])
    |=> cfg_rdata[31:24] == 8'h0)
    else $error("disabled read lane not zero");
  a_self_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE5]
    (cfg_req && blocked)
    |=> cfg_rdata == '0 && $stable(st_r.reg_num) && $stable(st_r.ext_reg_num))
    else $error("self-selected data access had an effect");
  a_self_drop: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE5]
    (cfg_req && cfg_we && blocked)
    |=> $stable(st_r.bridge_cfg) && $stable(st_r.action))
    else $error("self-selected data write reached a register");
  a_ecap_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE7]
    (cfg_req && !cfg_we && tgt == `ECIA_ADDR_ECAP && !blocked)
    |=> cfg_rdata == `ECIA_ECAP_VALUE)
    else $error("extended capability header not zero");
  a_bridge_direct: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE8]
    (cfg_req && cfg_we && cfg_addr == `ECIA_ADDR_BRIDGE && cfg_be == 4'hf)
    |=> st_r.bridge_cfg == $past(cfg_wdata))
    else $error("bridge configuration not writable");
  a_bridge_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE8]
    !(cfg_req && cfg_we)
    |=> $stable(st_r.bridge_cfg))
    else $error("bridge configuration changed without a write");
  a_action_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE9]
    (cfg_req && cfg_we && cfg_addr == `ECIA_ADDR_INTCTL && cfg_be[0])
    |=> st_r.action == $past(cfg_wdata[2:0]))
    else $error("action field not written");
  a_action_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE9]
    (cfg_req && !cfg_we && cfg_addr == `ECIA_ADDR_INTCTL && cfg_be == 4'hf)
    |=> cfg_rdata == {29'h0, $past(st_r.action)})
    else $error("action field read back wrong");
  c_ind_write: cover property (@(posedge sys_clk) disable iff (!rst_n) cfg_req && cfg_we && is_ind && !blocked);
  c_self_sel: cover property (@(posedge sys_clk) disable iff (!rst_n) cfg_req && blocked);
  c_ind_read: cover property (@(posedge sys_clk) disable iff (!rst_n) cfg_req && !cfg_we && is_ind);
endmodule
`default_nettype wire

// ===== verif/ecia_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// config requester model
// ****************************************
// only this side's registers are ever addressed
module ecia_host (
  input wire logic sys_clk,
  output logic cfg_req,
  output logic cfg_we,
  output ecia_pkg::ecia_addr_t cfg_addr,
  output ecia_pkg::ecia_be_t cfg_be,
  output ecia_pkg::ecia_word_t cfg_wdata,
  input wire logic cfg_ack,
  input wire ecia_pkg::ecia_word_t cfg_rdata
);
  import ecia_pkg::*;
  initial begin
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_addr = 12'h0;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end
  task automatic acc(input logic we, input ecia_addr_t a, input ecia_be_t be, input ecia_word_t d,
                     output ecia_word_t rd, output bit ok);
    ok = 1'b0;
    rd = 32'h0;
    @(posedge sys_clk);
    cfg_req <= 1'b1;
    cfg_we <= we;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge sys_clk);
    // one pulse per access; released address and data lines show junk, not the old value
    cfg_req <= 1'b0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
    for (int i = 0; i < 4 && !ok; i++) begin
      // answer taken at the edge that samples it high
      @(posedge sys_clk);
      if (cfg_ack === 1'b1) begin
        ok = 1'b1;
        rd = cfg_rdata;
      end
    end
  endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ecia_pkg::*;
  logic sys_clk, rst_n, link_up_status, msi_enable, legacy_interrupt_disable;
  logic cfg_req, cfg_we, cfg_ack, msi_send, intx_assert, intx_negate;
  ecia_addr_t cfg_addr;
  ecia_be_t cfg_be;
  ecia_word_t cfg_wdata, cfg_rdata;
  ecia_pin_t intx_pin, pin_seen;
  int n_fail, total_checks, n_msi, n_as, n_neg;
  logic [31:0] lf = 32'h2512, m_adr = 32'h0, m_brg = 32'h0, m_act = 32'h0, rd, r, d;
  ecia_addr_t a;
  ecia_addr_t tab [6] = '{12'h0f8, 12'h0fc, 12'h100, 12'h200, 12'h210, 12'h0a0};
  bit ok;
  ecia_top uut (.sys_clk, .rst_n, .cfg_req, .cfg_we, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack,
    .cfg_rdata, .link_up_status, .msi_enable, .legacy_interrupt_disable, .msi_send, .intx_assert,
    .intx_negate, .intx_pin);
  ecia_host host (.sys_clk, .cfg_req, .cfg_we, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // pulses are counted, so a stuck-high output shows up as a count above one
  always @(posedge sys_clk) begin
    if (msi_send === 1'b1) n_msi++;
    if (intx_assert === 1'b1) begin
      n_as++;
      pin_seen = intx_pin;
    end
    if (intx_negate === 1'b1) n_neg++;
  end
  // ****************************************
  // reference model
  // ****************************************
  function automatic logic [31:0] nx();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  function automatic logic [31:0] lm(input ecia_be_t be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction
  function automatic logic [31:0] mrd(input ecia_addr_t ea);
    case (ea)
      12'h0f8: return m_adr;
      12'h200: return m_brg;
      12'h210: return m_act;
      default: return 32'h0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic op(input logic we, input ecia_addr_t ad, input ecia_be_t be, input ecia_word_t wd);
    ecia_addr_t ea;
    logic [31:0] ex, n;
    ea = (ad == 12'h0fc) ? m_adr[11:0] : ad;
    ex = (ea == 12'h0fc) ? 32'h0 : mrd(ea) & lm(be);
    if (we) begin
      ex = 32'h0;
      n = (mrd(ea) & ~lm(be)) | (wd & lm(be));
      if (ea == 12'h0f8) m_adr = n & 32'h0000_0ffc;
      if (ea == 12'h200) m_brg = n;
      if (ea == 12'h210) m_act = n & 32'h7;
    end
    host.acc(we, ad, be, wd, rd, ok);
    if (!ok) begin
      n_fail++;
      end_of_test();
    end else begin
      chk(rd, ex);
    end
  endtask
  task automatic ntf(input logic [2:0] code, input logic en);
    logic e_msi, e_as;
    e_msi = (code == 3'h1) && en;
    e_as = (code >= 3'h2) && (code <= 3'h5) && en;
    op(1'b1, 12'h210, 4'hf, {29'h0, code});
    n_msi = 0;
    n_as = 0;
    n_neg = 0;
    @(posedge sys_clk);
    msi_enable <= en;
    legacy_interrupt_disable <= !en;
    link_up_status <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(32'(n_msi), 32'(e_msi));
    chk(32'(n_as), 32'(e_as));
    if (e_as) chk(32'(pin_seen), 32'(code - 3'h2));
    // action left alone while the status bit is up
    @(posedge sys_clk);
    link_up_status <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(32'(n_neg), 32'(e_as));
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    link_up_status = 1'b0;
    msi_enable = 1'b0;
    legacy_interrupt_disable = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (tab[i]) op(1'b0, tab[i], 4'hf, 32'h0);
    $display("test reset values done");
    op(1'b1, 12'h0f8, 4'hf, 32'hffff_f200);
    op(1'b1, 12'h0fc, 4'h5, 32'h1234_5678);
    op(1'b0, 12'h200, 4'hf, 32'h0);
    op(1'b1, 12'h0f8, 4'hf, 32'h0000_00fc);
    op(1'b1, 12'h0fc, 4'hf, 32'hdead_beef);
    op(1'b0, 12'h0fc, 4'hf, 32'h0);
    op(1'b0, 12'h0f8, 4'hf, 32'h0);
    $display("test indirect path done");
    // noise outside the index fields checks that they are masked off
    for (int i = 0; i < 300; i++) begin
      a = tab[nx() % 6];
      d = nx();
      if (a == 12'h0f8) d = (d & 32'hffff_f003) | {20'h0, tab[nx() % 6]};
      r = nx();
      op(r[0], a, r[4:1], d);
    end
    $display("test random access done");
    for (int c = 0; c < 8; c++) begin
      ntf(3'(c), 1'b0);
      ntf(3'(c), 1'b1);
    end
    $display("test link notification done");
    end_of_test();
  end
endmodule
`default_nettype wire
